// ==== bench/tb_top.sv ====
// Self-checking bench for the timer B block: registers, counting modes, prescaler, PWM pin and buzzer.
// Assumes the design compiles with timer_b_pkg; the bench drives every port itself, no partner model.

`default_nettype none

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import timer_b_pkg::*;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	logic ack, pin, pin_oe, buzz, uf_flag;
	logic instr_tick = 1'b0, ext_pin = 1'b0, gpio_out = 1'b0, gpio_oe = 1'b0;
	int num_errors = 0;
	int total_checks = 0;
	int seed = 7;

	timer_b_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.instr_tick_i(instr_tick), .external_count_input_i(ext_pin), .gpio_out_i(gpio_out),
		.gpio_oe_i(gpio_oe), .pwm_b_port_pin_o(pin), .pwm_b_port_pin_oe_o(pin_oe),
		.buzzer_b_o(buzz), .underflow_flag_o(uf_flag));

	initial begin
		forever #2.5 clk_i = ~clk_i;
	end

	// ------------------------------------------------------------
	// Bus and stimulus tasks
	// ------------------------------------------------------------
	// Ack is registered, so it is sampled at the edge after it rises
	task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d, output logic [7:0] q);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		sel <= 4'hF;
		wdat <= {24'h00_0000, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			num_errors++;
			$display("mismatch bus_ack expected 1 seen %b", ack);
		end
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, idx, d, q);
	endtask

	task automatic chk_rd(input string nm, input logic [5:0] idx, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, idx, 8'h00, q);
		`CHK(nm, e, q)
	endtask

	// Shared high bits first, then the count write loads the counter
	task automatic load(input logic [9:0] v);
		wr(HIGH_IDX, {v[9:8], 6'h00});
		wr(COUNT_IDX, v[7:0]);
	endtask

	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk_i);
			instr_tick <= 1'b1;
			@(posedge clk_i);
			instr_tick <= 1'b0;
		end
		repeat (4) @(posedge clk_i);
	endtask

	task automatic done(input string s);
		$display("test %s done", s);
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Counter after n decrement events, from the mode bits
	function automatic logic [9:0] model(logic [9:0] c, int n, logic rl, logic os, logic [9:0] rel);
		for (int i = 0; i < n; i++) begin
			if (c != 10'h000) c = c - 10'h001;
			else if (!os) c = rl ? rel : 10'h3FF;
		end
		return c;
	endfunction

	// Instruction ticks held high, so a wrong source choice shows up
	task automatic ext_run(input logic edge_fall, input int n);
		logic [9:0] e;
		wr(CTRL1_IDX, 8'h00);
		wr(CTRL2_IDX, {2'b00, 1'b1, edge_fall, 1'b1, 3'b000});
		load(10'h100);
		@(posedge clk_i);
		instr_tick <= 1'b1;
		wr(CTRL1_IDX, 8'h01);
		for (int i = 0; i < n; i++) begin
			repeat (4) @(posedge clk_i);
			ext_pin <= 1'b1;
			repeat (4) @(posedge clk_i);
			if (i < n - 1) ext_pin <= 1'b0;
		end
		repeat (6) @(posedge clk_i);
		wr(CTRL1_IDX, 8'h00);
		instr_tick <= 1'b0;
		ext_pin <= 1'b0;
		repeat (6) @(posedge clk_i);
		e = 10'h100 - (edge_fall ? n - 1 : n);
		chk_rd("ext_count", COUNT_IDX, e[7:0]);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] r;
		logic [9:0] cnt, dt, e;
		logic al, on, raw;
		int n, k;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		chk_rd("ctrl1_rst", CTRL1_IDX, CTRL1_RST);
		chk_rd("ctrl2_rst", CTRL2_IDX, CTRL2_RST);
		chk_rd("duty_wo", DUTY_IDX, BYTE_ZERO);
		chk_rd("buz_wo", BUZ_IDX, BYTE_ZERO);
		chk_rd("psv_rst", PSV_IDX, PS_RST);
		chk_rd("unmapped", 6'h20, BYTE_ZERO);
		wr(PSV_IDX, 8'h12);
		chk_rd("psv_ro", PSV_IDX, PS_RST);
		done("reset");
		for (int i = 0; i < 16; i++) begin
			r = $random(seed);
			cnt = r[9:0];
			dt = (i == 3) ? cnt : r[19:10];
			al = r[20];
			on = r[21] | i[1];
			wr(HIGH_IDX, {cnt[9:8], 2'b00, dt[9:8], 2'b00});
			wr(COUNT_IDX, cnt[7:0]);
			wr(DUTY_IDX, dt[7:0]);
			wr(BUZ_IDX, {on, 3'b000, i[3:0]});
			wr(CTRL1_IDX, {i[0], al, 6'h00});
			gpio_out <= r[22];
			gpio_oe <= r[23];
			repeat (4) @(posedge clk_i);
			raw = (cnt < dt) ^ al;
			`CHK("pin", i[0] ? raw : r[22], pin)
			`CHK("pin_oe", i[0] ? 1'b1 : r[23], pin_oe)
			`CHK("buzzer", on & (i[3] ? cnt[i[2:0]] : 1'b1), buzz)
		end
		done("pwm_buzzer");
		wr(CTRL1_IDX, 8'h00);
		wr(CTRL2_IDX, 8'h08);
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			cnt = r[9:0] | 10'h010;
			n = r[12:10] + 1;
			load(cnt);
			chk_rd("count_load", COUNT_IDX, cnt[7:0]);
			ticks(3);
			chk_rd("count_stop", COUNT_IDX, cnt[7:0]);
			wr(CTRL1_IDX, 8'h01);
			ticks(n);
			wr(CTRL1_IDX, 8'h00);
			e = model(cnt, n, 1'b0, 1'b0, cnt);
			chk_rd("count_run", COUNT_IDX, e[7:0]);
		end
		done("count");
		for (int m = 0; m < 3; m++) begin
			r = $random(seed);
			cnt = {8'h00, r[1:0]} + 10'h001;
			n = r[4:2] + 5;
			wr(STAT_IDX, 8'h01);
			load(cnt);
			wr(CTRL1_IDX, {5'b00000, m[1], m[0], 1'b1});
			ticks(n);
			e = model(cnt, n, m[0], m[1], cnt);
			chk_rd("underflow", COUNT_IDX, e[7:0]);
			`CHK("uf_flag", 1'b1, uf_flag)
			chk_rd("status", STAT_IDX, 8'h01);
			if (m == 2) chk_rd("os_run", CTRL1_IDX, 8'h04);
			wr(CTRL1_IDX, 8'h00);
			wr(STAT_IDX, 8'h01);
			// Clear lands at the ack edge; look one edge later
			@(posedge clk_i);
			`CHK("uf_clear", 1'b0, uf_flag)
		end
		done("underflow");
		for (int p = 0; p < 3; p++) begin
			k = 4 << (p + 1);
			wr(CTRL2_IDX, 8'h08 | p[7:0]);
			wr(CTRL2_IDX, 8'h00 | p[7:0]);
			load(10'h200);
			wr(CTRL1_IDX, 8'h01);
			ticks(k);
			wr(CTRL1_IDX, 8'h00);
			chk_rd("prescaled", COUNT_IDX, 8'hFC);
			chk_rd("psv_live", PSV_IDX, k[7:0] - 8'h01);
			wr(CTRL2_IDX, 8'h08);
			chk_rd("psv_off", PSV_IDX, PS_RST);
		end
		done("prescaler");
		ext_run(1'b0, 3);
		ext_run(1'b1, 4);
		done("external");
		close_out();
	end

	initial begin
		#100_000;
		num_errors++;
		$display("mismatch watchdog expected done seen hang");
		close_out();
	end

endmodule // tb_top

`default_nettype wire

// ==== logic/timer_b_pkg.sv ====
// Constants of the timer B block: register indices, field positions, reset values.
// Assumes a 32-bit classic Wishbone slave; byte address is four times the index.
//
// Overview of operation
// - Reading the count register returns the low eight counter bits.
// - Writing the count register loads the counter with shared high bits and data.
// - The counter decrements only while the run bit is one.
// - Non-stop, reload-select zero: underflow reloads 0x3FF and counting continues.
// - Non-stop, reload-select one: underflow reloads the programmed reload value.
// - One-shot mode counts down to zero, then stops.
// - Active-low bit one inverts the PWM output; zero leaves it active high.
// - PWM pin enable drives the pin with PWM, else the pin is plain I/O.
// - Prescaler ratio code selects division 1:2 up to 1:256 in powers of two.
// - Prescaler off bit one bypasses the prescaler; zero enables it.
// - External clock decrements on falling edge when edge-select is one, else rising.
// - Source-select one picks the external count input, zero the instruction clock.
// - Non-stop, reload-select one: the PWM frame period is the 10-bit reload value plus one.
// - PWM duty is shared high bits 3:2 above the duty low register.
// - Buzzer codes 0-7 pick prescaler taps, codes 8-15 pick counter bits 0-7.
// - Buzzer on bit one enables the buzzer output, zero holds it low.
// - The prescaler value register reads the live prescaler count, read-only.

`default_nettype none

package timer_b_pkg;

	// ------------------------------------------------------------
	// Register indices
	// ------------------------------------------------------------
	localparam int IDX_W = 6;
	localparam logic [5:0] COUNT_IDX = 6'h09;
	localparam logic [5:0] CTRL1_IDX = 6'h0A;
	localparam logic [5:0] CTRL2_IDX = 6'h0B;
	localparam logic [5:0] DUTY_IDX = 6'h0C;
	localparam logic [5:0] PSV_IDX = 6'h0D;
	localparam logic [5:0] BUZ_IDX = 6'h0E;
	localparam logic [5:0] HIGH_IDX = 6'h10;
	localparam logic [5:0] STAT_IDX = 6'h11;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int RUN_BIT = 0;
	localparam int RELOAD_SEL_BIT = 1;
	localparam int ONE_SHOT_BIT = 2;
	localparam int ACTIVE_LOW_BIT = 6;
	localparam int PIN_EN_BIT = 7;
	localparam int RATIO_LSB = 0;
	localparam int PS_OFF_BIT = 3;
	localparam int EDGE_SEL_BIT = 4;
	localparam int SRC_SEL_BIT = 5;
	localparam int BUZ_ON_BIT = 7;
	localparam int HIGH_RELOAD_LSB = 6;
	localparam int HIGH_DUTY_LSB = 2;
	localparam int UF_FLAG_BIT = 0;

	// ------------------------------------------------------------
	// Widths and values
	// ------------------------------------------------------------
	localparam int CNT_W = 10;
	localparam logic [7:0] CTRL1_RST = 8'h00;
	localparam logic [7:0] CTRL2_RST = 8'h3F;
	localparam logic [7:0] BUZ_RST = 8'h0F;
	localparam logic [7:0] PS_RST = 8'hFF;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [9:0] CNT_MAX = 10'h3FF;
	localparam logic [9:0] CNT_ZERO = 10'h000;
	localparam logic [9:0] CNT_ONE = 10'h001;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage

`default_nettype wire

// ==== logic/timer_b_prescaler.sv ====
// Eight-bit prescaler counter with power-of-two tick taps.
// Assumes event_i is a one-cycle pulse in the clk_i domain.

`default_nettype none

module timer_b_prescaler (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic event_i,
	input wire logic off_i,
	input wire logic [2:0] ratio_i,
	// Results
	output logic tick_o,
	output logic [7:0] value_o
);
	import timer_b_pkg::*;

	typedef struct packed {
		logic [7:0] cnt;
	} ps_state_t;

	ps_state_t s_reg;
	ps_state_t s_next;
	logic [7:0] tap_mask;

	// division ratio
	// A tick when the low ratio+1 bits are all ones and wrap on this event
	always_comb begin
		s_next = s_reg;
		tap_mask = 8'(({1'b0, 8'h01} << ({1'b0, ratio_i} + 4'h1)) - 9'h001);
		tick_o = 1'b0;
		if (off_i) begin
			s_next.cnt = PS_RST;
		end else if (event_i) begin
			s_next.cnt = s_reg.cnt + 8'h01;
			tick_o = (s_reg.cnt & tap_mask) == tap_mask;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '{cnt: PS_RST};
		end else begin
			s_reg <= s_next;
		end
	end

	assign value_o = s_reg.cnt;

endmodule // timer_b_prescaler

`default_nettype wire

// ==== logic/timer_b_top.sv ====
// Timer B: 10-bit down counter with prescaler, PWM pin and buzzer output.
// Assumes a classic Wishbone master on clk_i and an asynchronous external count pin.
//
// Added by the designer: register access over Wishbone.

`default_nettype none

module timer_b_top (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Clock sources
	input wire logic instr_tick_i,
	input wire logic external_count_input_i,
	// General-purpose side of the shared pin
	input wire logic gpio_out_i,
	input wire logic gpio_oe_i,
	// Pin, buzzer and underflow flag
	output logic pwm_b_port_pin_o,
	output logic pwm_b_port_pin_oe_o,
	output logic buzzer_b_o,
	output logic underflow_flag_o
);
	import timer_b_pkg::*;

	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic [7:0] timer_b_control_one;
		logic [7:0] timer_b_control_two;
		logic [7:0] pwm_b_duty_low;
		logic [7:0] buzzer_b_control;
		logic [7:0] shared_high_bits;
		logic [7:0] reload_low;
		logic [CNT_W-1:0] cnt;
		logic uf_flag;
		logic [2:0] ext_sync;
		logic pin;
		logic pin_oe;
		logic buzz;
	} top_state_t;

	top_state_t s_reg;
	top_state_t s_next;

	logic ps_tick;
	logic [7:0] prescaler_b_value;
	logic src_event;
	logic dec_tick;
	logic ext_rise;
	logic ext_fall;
	logic req;
	logic wr;
	logic [IDX_W-1:0] idx;
	logic underflow;
	logic pwm_raw;
	logic [CNT_W-1:0] reload_val;
	logic [CNT_W-1:0] duty_val;
	logic [7:0] rd_byte;
	logic [3:0] bsel;

	// ------------------------------------------------------------
	// Prescaler
	// ------------------------------------------------------------
	timer_b_prescaler u_prescaler (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(src_event),
		.off_i(s_reg.timer_b_control_two[PS_OFF_BIT]),
		.ratio_i(s_reg.timer_b_control_two[RATIO_LSB+2:RATIO_LSB]),
		.tick_o(ps_tick),
		.value_o(prescaler_b_value)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		idx = wb_adr_i[IDX_W+1:2];
		req = wb_cyc_i & wb_stb_i;
		// Write takes effect at the edge that samples ack high
		wr = req & wb_we_i & s_reg.ack & wb_sel_i[0];
		s_next.ack = req & ~s_reg.ack;

		// External pin: first stage feeds only the second
		s_next.ext_sync = {s_reg.ext_sync[1:0], external_count_input_i};
		ext_rise = s_reg.ext_sync[1] & ~s_reg.ext_sync[2];
		ext_fall = ~s_reg.ext_sync[1] & s_reg.ext_sync[2];

		if (s_reg.timer_b_control_two[SRC_SEL_BIT]) begin
			src_event = s_reg.timer_b_control_two[EDGE_SEL_BIT] ? ext_fall : ext_rise;
		end else begin
			src_event = instr_tick_i;
		end
		dec_tick = s_reg.timer_b_control_two[PS_OFF_BIT] ? src_event : ps_tick;

		reload_val = {s_reg.shared_high_bits[HIGH_RELOAD_LSB+1:HIGH_RELOAD_LSB], s_reg.reload_low};
		// duty from shared bits and duty low
		duty_val = {s_reg.shared_high_bits[HIGH_DUTY_LSB+1:HIGH_DUTY_LSB], s_reg.pwm_b_duty_low};

		unique case (idx)
			COUNT_IDX: rd_byte = s_reg.cnt[7:0];
			CTRL1_IDX: rd_byte = s_reg.timer_b_control_one;
			CTRL2_IDX: rd_byte = s_reg.timer_b_control_two;
			PSV_IDX: rd_byte = prescaler_b_value;
			HIGH_IDX: rd_byte = s_reg.shared_high_bits;
			STAT_IDX: rd_byte = {7'h00, s_reg.uf_flag};
			default: rd_byte = BYTE_ZERO;
		endcase
		if (req & ~s_reg.ack) begin
			s_next.rdat = {24'h00_0000, rd_byte};
		end

		// Counter
		underflow = 1'b0;
		if (wr && idx == COUNT_IDX) begin
			s_next.reload_low = wb_dat_i[7:0];
			s_next.cnt = {s_reg.shared_high_bits[HIGH_RELOAD_LSB+1:HIGH_RELOAD_LSB], wb_dat_i[7:0]};
		end else if (s_reg.timer_b_control_one[RUN_BIT] && dec_tick) begin
			if (s_reg.cnt == CNT_ZERO) begin
				underflow = 1'b1;
				if (s_reg.timer_b_control_one[ONE_SHOT_BIT]) begin
					s_next.timer_b_control_one[RUN_BIT] = 1'b0;
				end else if (s_reg.timer_b_control_one[RELOAD_SEL_BIT]) begin
					s_next.cnt = reload_val;
				end else begin
					s_next.cnt = CNT_MAX;
				end
			end else begin
				s_next.cnt = s_reg.cnt - CNT_ONE;
			end
		end

		// Register writes; software write beats the one-shot stop
		if (wr) begin
			unique case (idx)
				CTRL1_IDX: s_next.timer_b_control_one = wb_dat_i[7:0];
				// ratio written as given, whether prescaler off or on
				CTRL2_IDX: s_next.timer_b_control_two = wb_dat_i[7:0];
				DUTY_IDX: s_next.pwm_b_duty_low = wb_dat_i[7:0];
				BUZ_IDX: s_next.buzzer_b_control = wb_dat_i[7:0];
				HIGH_IDX: s_next.shared_high_bits = wb_dat_i[7:0];
				default: ;
			endcase
		end

		// sticky underflow flag, set beats clear
		s_next.uf_flag = (s_reg.uf_flag & ~(wr && idx == STAT_IDX && wb_dat_i[UF_FLAG_BIT])) | underflow;

		pwm_raw = (s_reg.cnt < duty_val) ^ s_reg.timer_b_control_one[ACTIVE_LOW_BIT];
		if (s_reg.timer_b_control_one[PIN_EN_BIT]) begin
			s_next.pin = pwm_raw;
			s_next.pin_oe = 1'b1;
		end else begin
			s_next.pin = gpio_out_i;
			s_next.pin_oe = gpio_oe_i;
		end

		bsel = s_reg.buzzer_b_control[3:0];
		s_next.buzz = s_reg.buzzer_b_control[BUZ_ON_BIT]
			& (bsel[3] ? s_reg.cnt[bsel[2:0]] : prescaler_b_value[bsel[2:0]]);
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '{
				ack: 1'b0,
				rdat: WORD_ZERO,
				timer_b_control_one: CTRL1_RST,
				timer_b_control_two: CTRL2_RST,
				pwm_b_duty_low: BYTE_ZERO,
				buzzer_b_control: BUZ_RST,
				shared_high_bits: BYTE_ZERO,
				reload_low: BYTE_ZERO,
				cnt: CNT_ZERO,
				uf_flag: 1'b0,
				ext_sync: 3'h0,
				pin: 1'b0,
				pin_oe: 1'b0,
				buzz: 1'b0
			};
		end else begin
			s_reg <= s_next;
		end
	end

	assign wb_ack_o = s_reg.ack;
	assign wb_dat_o = s_reg.rdat;
	assign pwm_b_port_pin_o = s_reg.pin;
	assign pwm_b_port_pin_oe_o = s_reg.pin_oe;
	assign buzzer_b_o = s_reg.buzz;
	assign underflow_flag_o = s_reg.uf_flag;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	count_read_a: assert property (
		(req && !wb_we_i && !s_reg.ack && idx == COUNT_IDX)
		|=> wb_ack_o && wb_dat_o == {24'h00_0000, $past(s_reg.cnt[7:0])})
		else $error("count read data wrong");

	count_load_a: assert property (
		(wr && idx == COUNT_IDX)
		|=> s_reg.cnt == {$past(s_reg.shared_high_bits[HIGH_RELOAD_LSB+1:HIGH_RELOAD_LSB]), $past(wb_dat_i[7:0])})
		else $error("count write did not load counter");

	stop_hold_a: assert property (
		(!s_reg.timer_b_control_one[RUN_BIT] && !(wr && idx == COUNT_IDX))
		|=> $stable(s_reg.cnt))
		else $error("counter moved while stopped");

	reload_max_a: assert property (
		(underflow && s_reg.timer_b_control_one[2:1] == 2'b00 && !wr)
		|=> s_reg.cnt == CNT_MAX)
		else $error("no full reload on underflow");

	reload_val_a: assert property (
		(underflow && s_reg.timer_b_control_one[2:1] == 2'b01 && !wr)
		|=> s_reg.cnt == $past(reload_val))
		else $error("no programmed reload on underflow");

	one_shot_a: assert property (
		(underflow && s_reg.timer_b_control_one[ONE_SHOT_BIT] && !wr)
		|=> s_reg.cnt == CNT_ZERO && !s_reg.timer_b_control_one[RUN_BIT])
		else $error("one-shot did not stop at zero");

	pwm_level_a: assert property (
		s_reg.timer_b_control_one[PIN_EN_BIT]
		|=> pwm_b_port_pin_oe_o
		&& pwm_b_port_pin_o == (($past(s_reg.cnt) < $past(duty_val)) ^ $past(s_reg.timer_b_control_one[ACTIVE_LOW_BIT])))
		else $error("pwm pin level wrong");

	gpio_pass_a: assert property (
		!s_reg.timer_b_control_one[PIN_EN_BIT]
		|=> pwm_b_port_pin_o == $past(gpio_out_i) && pwm_b_port_pin_oe_o == $past(gpio_oe_i))
		else $error("gpio not passed to pin");

	buzzer_off_a: assert property (
		!s_reg.buzzer_b_control[BUZ_ON_BIT] |=> !buzzer_b_o)
		else $error("buzzer active while off");

	flag_set_a: assert property (
		underflow |=> underflow_flag_o)
		else $error("underflow not flagged");

	bypass_tick_a: assert property (
		(s_reg.timer_b_control_two[PS_OFF_BIT] && s_reg.timer_b_control_one[RUN_BIT]
		&& src_event && s_reg.cnt != CNT_ZERO && !wr)
		|=> s_reg.cnt == $past(s_reg.cnt) - CNT_ONE)
		else $error("bypassed prescaler did not decrement");

	psv_read_a: assert property (
		(req && !wb_we_i && !s_reg.ack && idx == PSV_IDX)
		|=> wb_ack_o && wb_dat_o == {24'h00_0000, $past(prescaler_b_value)})
		else $error("prescaler value read wrong");

	ext_rise_a: assert property (
		(s_reg.timer_b_control_two[SRC_SEL_BIT] && !s_reg.timer_b_control_two[EDGE_SEL_BIT]
		&& s_reg.timer_b_control_two[PS_OFF_BIT] && s_reg.timer_b_control_one[RUN_BIT]
		&& ext_rise && s_reg.cnt != CNT_ZERO && !wr)
		|=> s_reg.cnt == $past(s_reg.cnt) - CNT_ONE)
		else $error("rising external edge not counted");

	ext_fall_a: assert property (
		(s_reg.timer_b_control_two[SRC_SEL_BIT] && s_reg.timer_b_control_two[EDGE_SEL_BIT]
		&& s_reg.timer_b_control_two[PS_OFF_BIT] && s_reg.timer_b_control_one[RUN_BIT]
		&& ext_fall && s_reg.cnt != CNT_ZERO && !wr)
		|=> s_reg.cnt == $past(s_reg.cnt) - CNT_ONE)
		else $error("falling external edge not counted");

	instr_step_a: assert property (
		(!s_reg.timer_b_control_two[SRC_SEL_BIT] && s_reg.timer_b_control_two[PS_OFF_BIT]
		&& s_reg.timer_b_control_one[RUN_BIT] && instr_tick_i && s_reg.cnt != CNT_ZERO && !wr)
		|=> s_reg.cnt == $past(s_reg.cnt) - CNT_ONE)
		else $error("instruction tick not counted");

	ext_only_a: assert property (
		(s_reg.timer_b_control_two[SRC_SEL_BIT] && !ext_rise && !ext_fall && !wr)
		|=> $stable(s_reg.cnt))
		else $error("counter moved without external edge");

	ps_hold_a: assert property (
		(!s_reg.timer_b_control_two[PS_OFF_BIT] && !ps_tick && !wr)
		|=> $stable(s_reg.cnt))
		else $error("counter moved without prescaler tick");

	ps_off_a: assert property (
		s_reg.timer_b_control_two[PS_OFF_BIT] |=> prescaler_b_value == PS_RST)
		else $error("disabled prescaler not held");

	tick_half_a: assert property (
		(!s_reg.timer_b_control_two[PS_OFF_BIT] && s_reg.timer_b_control_two[RATIO_LSB+2:RATIO_LSB] == 3'b000)
		|-> ps_tick == (src_event && prescaler_b_value[0]))
		else $error("prescaler half rate tick wrong");

	tick_quarter_a: assert property (
		(!s_reg.timer_b_control_two[PS_OFF_BIT] && s_reg.timer_b_control_two[RATIO_LSB+2:RATIO_LSB] == 3'b001)
		|-> ps_tick == (src_event && prescaler_b_value[1:0] == 2'b11))
		else $error("prescaler quarter rate tick wrong");

	duty_idle_a: assert property (
		(s_reg.timer_b_control_one[PIN_EN_BIT] && !s_reg.timer_b_control_one[ACTIVE_LOW_BIT]
		&& s_reg.cnt >= {s_reg.shared_high_bits[HIGH_DUTY_LSB+1:HIGH_DUTY_LSB], s_reg.pwm_b_duty_low})
		|=> !pwm_b_port_pin_o)
		else $error("pwm active beyond duty");

	buzzer_tap_a: assert property (
		(s_reg.buzzer_b_control[BUZ_ON_BIT] && bsel[3])
		|=> buzzer_b_o == $past(s_reg.cnt[bsel[2:0]]))
		else $error("buzzer counter tap wrong");

	buzzer_ps_a: assert property (
		(s_reg.buzzer_b_control[BUZ_ON_BIT] && !bsel[3])
		|=> buzzer_b_o == $past(prescaler_b_value[bsel[2:0]]))
		else $error("buzzer prescaler tap wrong");

endmodule // timer_b_top

`default_nettype wire
